/* core/pmc_pkg.sv */
/*
 * Shared constants and types of the power management control block:
 * register offsets, field positions, encodings and timing counts.
 * Assumes a 40 MHz core clock; the microsecond and millisecond counts below derive from that rate.
 */
package pmc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_ADDR      = 8'h84;
    localparam logic [7:0]  WAKE_TEST_ADDR = 8'h60;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field positions inside power_mgmt_control
    // ------------------------------------------------------------------
    localparam int B_READY  = 0;
    localparam int B_OUT_EN = 1;
    localparam int B_POL    = 2;
    localparam int B_PULSE  = 3;
    localparam int B_CAUSE  = 4;
    localparam int B_TYPE   = 6;
    localparam int B_ENERGY_DETECT_ENABLE  = 8;
    localparam int B_WAKE_FRAME_ENABLE = 9;
    localparam int B_PHY    = 10;
    localparam int B_PSS    = 12;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PSS_NORMAL = 2'h0;
    localparam logic [1:0] PSS_FRAME  = 2'h1;
    localparam logic [1:0] PSS_ENERGY = 2'h2;
    localparam int         C_ENERGY   = 0;
    localparam int         C_FRAME    = 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PHY_RESET_REQUEST_US    = 100;
    localparam int PHY_RESET_REQUEST_CYC   = (PHY_RESET_REQUEST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MS      = 50;
    localparam int PULSE_CYC     = (PULSE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int READY_CYC     = 64;
    localparam int TMR_W         = 22;

    typedef enum logic [1:0] {
        state_normal,
        state_wake_frame_detect,
        state_energy_detect
    } pmc_state_t;

endpackage

/* core/pmc_tmr_if.sv */
/*
 * Start/busy/done handshake between the control logic and one timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pmc_tmr_if #(parameter int W = 22);
    logic         start;
    logic [W-1:0] count;
    logic         busy;
    logic         done;
    modport ctl (output start, output count, input busy, input done);
    modport tmr (input start, input count, output busy, output done);
endinterface

/* core/pmc_timer.sv */
/*
 * One-shot down counter: a start loads count, busy stands for count
 * cycles, done pulses the cycle after the last one. A start while busy reloads.
 * Assumes count is at least one.
 */
`timescale 1ns/1ps
module pmc_timer #(
    parameter int W = 22
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    pmc_tmr_if.tmr    t
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         busy;
    logic         next_busy;
    logic         done;
    logic         next_done;

    // ------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------
    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (t.start) begin
            next_cnt  = t.count;
            next_busy = 1'b1;
        end else if (busy) begin
            next_cnt = cnt - W'(1);
            if (cnt == W'(1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign t.busy = busy;
    assign t.done = done;
endmodule

/* core/pmc_top.sv */
/*
 * Power management control: power state, PHY reset, wake cause status
 * and the external wake event pin, behind one 32-bit register.
 * Assumes a single-cycle host strobe interface synchronous to core_clk
 * and wake event sources that are logic on the same clock.
 */
`timescale 1ns/1ps
// Contract
// - control register reads answer correctly in every power state.
// - state field 00 normal, 01 frame detect, 10 energy detect; 11 ignored.
// - any write to the wake test address wakes a reduced-power device.
// - writing one to the PHY reset bit holds PHY reset at least 100 us.
// - PHY reset bit self-clears on release; writes ignored while high.
// - enabled frame wake event drives the pin if enabled, always the interrupt.
// - enabled energy event drives the pin if enabled, always the interrupt.
// - buffer type clear is open-drain active low; set is push-pull.
// - cause field 00 none, 01 energy, 10 frame, 11 both.
// - cause bits clear by one only when ready, normal, sources gone.
// - pulse mode drives the pin for 50 ms; static mode holds it.
// - pin drops when cause bits clear or matching enable clears.
// - push-pull polarity set is active high, clear is active low.
// - output enable gates only the pin, never the interrupt.
// - ready reads one only after stabilising; other accesses invalid before.
module pmc_top #(
    parameter int PULSE_CYC = pmc_pkg::PULSE_CYC,
    parameter int READY_CYC = pmc_pkg::READY_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        bus_cs,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    output logic      [31:0] bus_rdata,
    output logic             bus_rvalid,
    input  wire logic        wol_event,
    input  wire logic        energy_event,
    output logic             wake_event_output,
    output logic             wake_event_output_oe_n,
    output logic             wake_event_interrupt,
    output logic             phy_reset_out
);
    localparam int W = pmc_pkg::TMR_W;
    localparam logic [W-1:0] PHY_CNT = pmc_pkg::PHY_RESET_REQUEST_CYC[W-1:0];
    localparam logic [W-1:0] PLS_CNT = PULSE_CYC[W-1:0];
    localparam logic [W-1:0] RDY_CNT = READY_CYC[W-1:0];
    localparam int PHY_MIN = pmc_pkg::PHY_RESET_REQUEST_CYC;

    pmc_pkg::pmc_state_t state, next_state;
    logic        ready, next_ready;
    logic        unlock, next_unlock;
    logic        boot, next_boot;
    logic        wake_frame_enable, next_wake_frame_enable;
    logic        energy_detect_enable, next_energy_detect_enable;
    logic        event_out_buffer_type, next_event_out_buffer_type;
    logic        event_out_pulse_mode, next_event_out_pulse_mode;
    logic        event_out_polarity, next_event_out_polarity;
    logic        event_out_enable, next_event_out_enable;
    logic [1:0]  wake_cause_status, next_wake_cause_status;
    logic        next_phy_reset_out;
    logic        next_out, next_oe_n, next_irq, next_rvalid;
    logic [31:0] next_rdata, ctrl_word;
    logic [1:0]  power_state_select, cause_clr, cause_set;
    logic        rd_any, rd_ctrl, wr_any, wr_ctrl, wake, enter;
    logic        set_frame, set_energy, cause_on, pin_active;

    pmc_tmr_if #(.W(W)) phy_t ();
    pmc_tmr_if #(.W(W)) pls_t ();
    pmc_tmr_if #(.W(W)) rdy_t ();

    pmc_timer #(.W(W)) u_phy_tmr (.core_clk(core_clk), .rstn(rstn), .t(phy_t));
    pmc_timer #(.W(W)) u_pls_tmr (.core_clk(core_clk), .rstn(rstn), .t(pls_t));
    pmc_timer #(.W(W)) u_rdy_tmr (.core_clk(core_clk), .rstn(rstn), .t(rdy_t));

    // ------------------------------------------------------------------
    // access decode and events
    // ------------------------------------------------------------------
    assign rd_any  = bus_cs & bus_rd;
    assign rd_ctrl = rd_any & (bus_addr == pmc_pkg::CTRL_ADDR);
    assign wr_any  = bus_cs & bus_wr;
    // not ready covers sleep and wake-up settling alike
    assign wr_ctrl = wr_any & (bus_addr == pmc_pkg::CTRL_ADDR) & unlock & ready;
    assign wake    = wr_any & (bus_addr == pmc_pkg::WAKE_TEST_ADDR)
                   & (state != pmc_pkg::state_normal);
    assign enter   = wr_ctrl & ((bus_wdata[pmc_pkg::B_PSS+:2] == pmc_pkg::PSS_FRAME)
                   | (bus_wdata[pmc_pkg::B_PSS+:2] == pmc_pkg::PSS_ENERGY));
    assign set_frame  = wol_event & wake_frame_enable;
    assign set_energy = energy_event & energy_detect_enable;
    // a source still active blocks the clear of its own bit
    assign cause_clr = {2{wr_ctrl}} & bus_wdata[pmc_pkg::B_CAUSE+:2]
                     & ~{wol_event, energy_event};
    assign cause_set = {set_frame, set_energy};
    assign cause_on  = (wake_cause_status[pmc_pkg::C_FRAME] & wake_frame_enable)
                     | (wake_cause_status[pmc_pkg::C_ENERGY] & energy_detect_enable);
    assign pin_active = cause_on & event_out_enable
                      & (event_out_pulse_mode ? pls_t.busy : 1'b1);

    // timer requests
    assign phy_t.start = wr_ctrl & bus_wdata[pmc_pkg::B_PHY] & ~phy_reset_out;
    assign phy_t.count = PHY_CNT;
    assign pls_t.start = |(cause_set & ~wake_cause_status);
    assign pls_t.count = PLS_CNT;
    assign rdy_t.start = boot | wake;
    assign rdy_t.count = RDY_CNT;

    // ------------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------------
    always_comb begin
        unique case (state)
            pmc_pkg::state_normal:            power_state_select = pmc_pkg::PSS_NORMAL;
            pmc_pkg::state_wake_frame_detect: power_state_select = pmc_pkg::PSS_FRAME;
            pmc_pkg::state_energy_detect:     power_state_select = pmc_pkg::PSS_ENERGY;
            // the unused fourth code reads back as normal rather than inferring a latch
            default:                          power_state_select = pmc_pkg::PSS_NORMAL;
        endcase
        ctrl_word = pmc_pkg::CTRL_RST;
        ctrl_word[pmc_pkg::B_PSS+:2]   = power_state_select;
        ctrl_word[pmc_pkg::B_PHY]      = phy_reset_out;
        ctrl_word[pmc_pkg::B_WAKE_FRAME_ENABLE]   = wake_frame_enable;
        ctrl_word[pmc_pkg::B_ENERGY_DETECT_ENABLE]    = energy_detect_enable;
        ctrl_word[pmc_pkg::B_TYPE]     = event_out_buffer_type;
        ctrl_word[pmc_pkg::B_CAUSE+:2] = wake_cause_status;
        ctrl_word[pmc_pkg::B_PULSE]    = event_out_pulse_mode;
        ctrl_word[pmc_pkg::B_POL]      = event_out_polarity;
        ctrl_word[pmc_pkg::B_OUT_EN]   = event_out_enable;
        ctrl_word[pmc_pkg::B_READY]    = ready;
    end

    // ------------------------------------------------------------------
    // next state of the control group
    // ------------------------------------------------------------------
    always_comb begin
        next_state                 = state;
        next_ready                 = ready;
        next_unlock                = unlock;
        next_boot                  = 1'b0;
        next_wake_frame_enable     = wake_frame_enable;
        next_energy_detect_enable  = energy_detect_enable;
        next_event_out_buffer_type = event_out_buffer_type;
        next_event_out_pulse_mode  = event_out_pulse_mode;
        next_event_out_polarity    = event_out_polarity;
        next_event_out_enable      = event_out_enable;
        next_phy_reset_out         = phy_reset_out;
        // power state: field self-clears back to normal on wake
        if (wake) begin
            next_state  = pmc_pkg::state_normal;
            next_unlock = 1'b0;
        end else if (enter) begin
            next_state  = (bus_wdata[pmc_pkg::B_PSS+:2] == pmc_pkg::PSS_FRAME)
                        ? pmc_pkg::state_wake_frame_detect
                        : pmc_pkg::state_energy_detect;
            next_ready  = 1'b0;
            next_unlock = 1'b0;
        end
        if (rdy_t.done && state == pmc_pkg::state_normal) begin
            next_ready = 1'b1;
        end
        if (rd_any) begin
            next_unlock = 1'b1;
        end
        if (wr_ctrl) begin
            next_wake_frame_enable     = bus_wdata[pmc_pkg::B_WAKE_FRAME_ENABLE];
            next_energy_detect_enable  = bus_wdata[pmc_pkg::B_ENERGY_DETECT_ENABLE];
            next_event_out_buffer_type = bus_wdata[pmc_pkg::B_TYPE];
            next_event_out_pulse_mode  = bus_wdata[pmc_pkg::B_PULSE];
            next_event_out_polarity    = bus_wdata[pmc_pkg::B_POL];
            next_event_out_enable      = bus_wdata[pmc_pkg::B_OUT_EN];
        end
        if (phy_t.start) begin
            next_phy_reset_out = 1'b1;
        end else if (phy_t.done) begin
            next_phy_reset_out = 1'b0;
        end
        // set wins over a clear in the same cycle
        next_wake_cause_status = (wake_cause_status & ~cause_clr) | cause_set;
        // open-drain only ever pulls low; polarity is ignored there
        if (!event_out_buffer_type) begin
            next_out  = 1'b0;
            next_oe_n = ~pin_active;
        end else begin
            next_out  = event_out_polarity ? pin_active : ~pin_active;
            next_oe_n = 1'b0;
        end
        next_irq    = cause_on;
        next_rvalid = rd_any;
        next_rdata  = rd_ctrl ? ctrl_word : 32'h0000_0000;
    end

    // registers only
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state                  <= pmc_pkg::state_normal;
            ready                  <= 1'b0;
            unlock                 <= 1'b0;
            boot                   <= 1'b1;
            wake_frame_enable      <= 1'b0;
            energy_detect_enable   <= 1'b0;
            event_out_buffer_type  <= 1'b0;
            event_out_pulse_mode   <= 1'b0;
            event_out_polarity     <= 1'b0;
            event_out_enable       <= 1'b0;
            wake_cause_status      <= 2'h0;
            phy_reset_out          <= 1'b0;
            wake_event_output      <= 1'b0;
            wake_event_output_oe_n <= 1'b1;
            wake_event_interrupt   <= 1'b0;
            bus_rvalid             <= 1'b0;
            bus_rdata              <= 32'h0000_0000;
        end else begin
            state                  <= next_state;
            ready                  <= next_ready;
            unlock                 <= next_unlock;
            boot                   <= next_boot;
            wake_frame_enable      <= next_wake_frame_enable;
            energy_detect_enable   <= next_energy_detect_enable;
            event_out_buffer_type  <= next_event_out_buffer_type;
            event_out_pulse_mode   <= next_event_out_pulse_mode;
            event_out_polarity     <= next_event_out_polarity;
            event_out_enable       <= next_event_out_enable;
            wake_cause_status      <= next_wake_cause_status;
            phy_reset_out          <= next_phy_reset_out;
            wake_event_output      <= next_out;
            wake_event_output_oe_n <= next_oe_n;
            wake_event_interrupt   <= next_irq;
            bus_rvalid             <= next_rvalid;
            bus_rdata              <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [12:0] phy_hi_cnt;

    // helper: cycles the PHY reset has been high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phy_hi_cnt <= 13'h0000;
        end else begin
            phy_hi_cnt <= phy_reset_out ? phy_hi_cnt + 13'h0001 : 13'h0000;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_read_state: assert property (rd_ctrl |=> bus_rvalid
        && bus_rdata[pmc_pkg::B_PSS+:2] == $past(power_state_select))
        else $error("control read returned wrong power state");
    a_mode_reserved: assert property ((wr_ctrl && bus_wdata[pmc_pkg::B_PSS+:2] == 2'h3)
        |=> state == $past(state))
        else $error("reserved power state accepted");
    a_wake_write: assert property (wake |=> state == pmc_pkg::state_normal
        && !ready)
        else $error("wake write did not return to normal");
    a_phy_hold: assert property ($fell(phy_reset_out) |-> $past(phy_hi_cnt) >= PHY_MIN)
        else $error("phy reset released too early");
    a_phy_ignore: assert property ((phy_reset_out && !phy_t.done) |=> phy_reset_out)
        else $error("phy reset dropped before its timer");
    a_open_drain: assert property (!$past(event_out_buffer_type)
        |-> !wake_event_output)
        else $error("open-drain pin driven high");
    a_irq_ungated: assert property (cause_on && !event_out_enable
        |=> wake_event_interrupt && (wake_event_output_oe_n
            || ($past(event_out_buffer_type)
                && wake_event_output != $past(event_out_polarity))))
        else $error("interrupt gated or pin active while disabled");
    a_clear_blocked: assert property (!ready
        |=> (wake_cause_status & $past(wake_cause_status)) == $past(wake_cause_status))
        else $error("cause bit cleared while not ready");
    a_ready_sleep: assert property (state != pmc_pkg::state_normal |-> !ready)
        else $error("ready set in a reduced power state");
endmodule

/* tb/pmc_host.sv */
/*
 * Host processor model: drives the one-cycle strobe register bus of the
 * power management control block through rd and wr tasks.
 * Assumes a single core_clk shared with the device; requests change on
 * the falling edge so the device samples them settled on the rising one.
 */
`timescale 1ns/1ps
module pmc_host (
    input  wire logic        core_clk,
    output logic             bus_cs,
    output logic             bus_rd,
    output logic             bus_wr,
    output logic      [7:0]  bus_addr,
    output logic      [31:0] bus_wdata,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_rvalid
);
    // idle bus from time zero
    initial begin
        bus_cs    = 1'b0;
        bus_rd    = 1'b0;
        bus_wr    = 1'b0;
        bus_addr  = 8'h00;
        bus_wdata = 32'h0000_0000;
    end

    // one-cycle read; the answer stands one cycle, so it is taken then
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge core_clk);
        bus_cs   = 1'b1;
        bus_rd   = 1'b1;
        bus_addr = a;
        @(negedge core_clk);
        bus_cs = 1'b0;
        bus_rd = 1'b0;
        // a missing answer shows as unknown so it can never match
        d = (bus_rvalid === 1'b1) ? bus_rdata : 32'hxxxx_xxxx;
    endtask

    // one-cycle write; the caller keeps read-before-write order
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        bus_cs    = 1'b1;
        bus_wr    = 1'b1;
        bus_addr  = a;
        bus_wdata = d;
        @(negedge core_clk);
        bus_cs    = 1'b0;
        bus_wr    = 1'b0;
        bus_wdata = ~d; // stale data must not look like a held value
    endtask
endmodule

/* tb/power_mgmt_control_tb.sv */
/*
 * Self-checking bench of the power management control block: register
 * sequences through the host model, event sources driven directly.
 * Assumes short pulse and ready counts; the PHY reset count is the real one.
 */
`timescale 1ns/1ps
module power_mgmt_control_tb;
    localparam int PULSE = 20;
    localparam int READY = 4;
    localparam logic [7:0] CA = pmc_pkg::CTRL_ADDR;
    localparam logic [7:0] WA = pmc_pkg::WAKE_TEST_ADDR;

    logic        core_clk, rstn, wol_event, energy_event;
    logic        bus_cs, bus_rd, bus_wr, bus_rvalid;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata, bus_rdata, w;
    logic        pin_out, pin_oe_n, irq, phy_reset_request;
    int          fail_count, checked;

    always #12.5 core_clk = ~core_clk;

    pmc_host i_host (.core_clk(core_clk), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid));

    pmc_top #(.PULSE_CYC(PULSE), .READY_CYC(READY)) i_dut (.core_clk(core_clk), .rstn(rstn),
        .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .wol_event(wol_event), .energy_event(energy_event), .wake_event_output(pin_out),
        .wake_event_output_oe_n(pin_oe_n), .wake_event_interrupt(irq),
        .phy_reset_out(phy_reset_request));

    // ------------------------------------------------------------------
    // compare and helper tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_host.rd(a, w);
        chk_word(w, exp);
    endtask

    task automatic pin(input logic o, input logic oe_n, input logic i);
        chk_bit(pin_out, o, "pin data");
        chk_bit(pin_oe_n, oe_n, "pin enable");
        chk_bit(irq, i, "interrupt");
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // bounded poll; the polling reads also satisfy read-before-write
    task automatic wait_ready();
        for (int k = 0; k < 40; k++) begin
            i_host.rd(CA, w);
            if (w[0] === 1'b1)
                return;
        end
        chk_bit(w[0], 1'b1, "ready");
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: the run needs about 4200 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        wol_event = 1'b0;
        energy_event = 1'b0;
        fail_count = 0;
        checked = 0;
        cycles(20);
        pin(1'b0, 1'b1, 1'b0);
        rstn = 1'b1;
        rd_chk(CA, 32'h0000_0000);
        wait_ready();
        // push-pull, static: idle level then a frame event
        i_host.wr(CA, 32'h0000_0242);
        cycles(2);
        pin(1'b1, 1'b0, 1'b0);
        i_host.wr(CA, 32'h0000_0246);
        wol_event = 1'b1;
        cycles(3);
        pin(1'b1, 1'b0, 1'b1);
        i_host.wr(CA, 32'h0000_0266);
        rd_chk(CA, 32'h0000_0267);
        wol_event = 1'b0;
        i_host.wr(CA, 32'h0000_0266);
        rd_chk(CA, 32'h0000_0247);
        pin(1'b0, 1'b0, 1'b0);
        // open-drain, polarity bit set but ignored, both sources
        i_host.wr(CA, 32'h0000_0306);
        cycles(2);
        pin(1'b0, 1'b1, 1'b0);
        energy_event = 1'b1;
        cycles(3);
        pin(1'b0, 1'b0, 1'b1);
        rd_chk(CA, 32'h0000_0317);
        wol_event = 1'b1;
        cycles(2);
        rd_chk(CA, 32'h0000_0337);
        i_host.wr(CA, 32'h0000_0304);
        cycles(2);
        pin(1'b0, 1'b1, 1'b1);
        i_host.wr(CA, 32'h0000_0002);
        cycles(2);
        pin(1'b0, 1'b1, 1'b0);
        energy_event = 1'b0;
        wol_event = 1'b0;
        i_host.wr(CA, 32'h0000_0030);
        rd_chk(CA, 32'h0000_0001);
        // pulse mode: active for the pulse count, then idle with cause held
        i_host.wr(CA, 32'h0000_024e);
        wol_event = 1'b1;
        cycles(3);
        pin(1'b1, 1'b0, 1'b1);
        cycles(8);
        chk_bit(pin_out, 1'b1, "pin data");
        cycles(14);
        pin(1'b0, 1'b0, 1'b1);
        wol_event = 1'b0;
        i_host.wr(CA, 32'h0000_0020);
        rd_chk(CA, 32'h0000_0001);
        // power states: reserved code, sleep, refused write, wake
        i_host.wr(CA, 32'h0000_3000);
        rd_chk(CA, 32'h0000_0001);
        i_host.wr(CA, 32'h0000_1000);
        rd_chk(CA, 32'h0000_1000);
        i_host.wr(CA, 32'h0000_0206);
        rd_chk(CA, 32'h0000_1000);
        i_host.wr(WA, 32'h0000_0000);
        wait_ready();
        i_host.wr(CA, 32'h0000_2000);
        rd_chk(CA, 32'h0000_2000);
        i_host.wr(WA, 32'h1234_5678);
        cycles(20);
        i_host.wr(CA, 32'h0000_0200);
        rd_chk(CA, 32'h0000_0001);
        i_host.wr(CA, 32'h0000_0200);
        rd_chk(CA, 32'h0000_0201);
        // phy reset: a rewrite while held must not stretch it
        i_host.wr(CA, 32'h0000_0400);
        chk_bit(phy_reset_request, 1'b1, "phy reset");
        rd_chk(CA, 32'h0000_0401);
        cycles(1000);
        i_host.wr(CA, 32'h0000_0400);
        cycles(2980);
        chk_bit(phy_reset_request, 1'b1, "phy reset");
        cycles(20);
        chk_bit(phy_reset_request, 1'b0, "phy reset");
        rd_chk(CA, 32'h0000_0001);
        wrap_up();
    end
endmodule
